// ==== pps_pkg.sv ====
// Package of constants and types for the paper pickup sequencer
package pps_pkg;

   // ***************************************************
   // Register map (word addresses on the bus)
   // ***************************************************
   localparam logic [3:0] PPS_ADDR_CTRL = 4'h0;
   localparam logic [3:0] PPS_ADDR_STATUS = 4'h1;
   localparam logic [3:0] PPS_ADDR_SOL_DLY = 4'h2;
   localparam logic [3:0] PPS_ADDR_LIFT_TMO = 4'h3;
   localparam logic [3:0] PPS_ADDR_PICK_LEN = 4'h4;

   // ***************************************************
   // Control register fields
   // ***************************************************
   localparam int PPS_CTRL_START_BIT = 0;
   localparam int PPS_CTRL_TRAY_BIT = 1;
   localparam int PPS_CTRL_CONT_BIT = 2;
   localparam int PPS_CTRL_RAISE_BIT = 3;
   localparam int PPS_CTRL_LSCLR_BIT = 4;

   // ***************************************************
   // Status register fields
   // ***************************************************
   localparam int PPS_ST_SIZE_LSB = 0;
   localparam int PPS_ST_ABSENT_BIT = 4;
   localparam int PPS_ST_EMPTY_BIT = 5;
   localparam int PPS_ST_LFAULT_BIT = 6;
   localparam int PPS_ST_BYP_LOADED_BIT = 7;
   localparam int PPS_ST_BYP_OUT_BIT = 8;
   localparam int PPS_ST_BUSY_BIT = 9;
   localparam int PPS_ST_LIFTING_BIT = 10;

   // ***************************************************
   // Reset values and timing (ms based, at 50 MHz)
   // ***************************************************
   localparam int PPS_CLK_HZ = 50_000_000;
   localparam int PPS_TICK_US = 1000;
   localparam int PPS_TICK_CYCLES = PPS_CLK_HZ / 1_000_000 * PPS_TICK_US;
   localparam logic [15:0] PPS_SOL_DLY_RST = 16'h0032;
   localparam logic [15:0] PPS_LIFT_TMO_RST = 16'h0bb8;
   localparam logic [15:0] PPS_PICK_LEN_RST = 16'h00c8;

   // ***************************************************
   // Paper size codes
   // ***************************************************
   typedef enum logic [3:0] {
      PPS_SZ_NONE = 4'h0,
      PPS_SZ_A4 = 4'h1,
      PPS_SZ_LETTER = 4'h2,
      PPS_SZ_B5 = 4'h3,
      PPS_SZ_EXEC = 4'h4,
      PPS_SZ_A5R = 4'h5,
      PPS_SZ_B5R = 4'h6,
      PPS_SZ_LETTERR = 4'h7,
      PPS_SZ_A4R = 4'h8,
      PPS_SZ_A3 = 4'h9,
      PPS_SZ_LEDGER = 4'ha,
      PPS_SZ_B4 = 4'hb,
      PPS_SZ_LEGAL = 4'hc,
      PPS_SZ_UNKNOWN = 4'hf
   } pps_size_t;

endpackage

// ==== pps_paper_pickup_sequencer.sv ====
// Pickup, lifter and paper sensing sequencer with Wishbone registers
// How it works
// R1 - Print command starts pickup motor for the selected tray.
// R2 - Cassette pickup solenoid fires a configurable delay after motor start.
// R3 - Lifter raise launches at power-up and on cassette insertion.
// R4 - Lifter motor runs until stack surface sensor sees rack, then stops.
// R5 - Raise exceeding configurable timeout flags a lifter motor fault.
// R6 - Lift reruns when stack surface sensor loses the rack while no lifter fault is held.
// R7 - Top end switch is inverted presence: off means installed.
// R8 - Cassette absence is reported while presence input shows missing.
// R9 - Both end switches off: width decodes to seven small sizes.
// R10 - End patterns decode A4-R, A3, 11x17, B4 and Legal.
// R11 - Empty cassette reported while media-out sensor sees no paper.
// R12 - Bypass pickup energises bypass solenoid after motor start.
// R13 - Bypass media sensor is sampled to know tray loading.
// R14 - Last-sheet sensor watched during continuous bypass printing.
// R15 - Last-sheet detection reports bypass tray out of media.
// R16 - Lifter fault stops motor and holds until new raise or reset.
// R17 - Unlisted switch patterns with cassette present give unknown size.
`timescale 1ns/1ps

module pps_paper_pickup_sequencer
   import pps_pkg::*;
#(
   parameter int TICK_CYCLES = PPS_TICK_CYCLES
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [5:2] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Sensor and switch pins
   input wire logic [2:0] i_width_sw,
   input wire logic [2:0] i_end_sw,
   input wire logic i_stack_surface_sensor,
   input wire logic i_cassette_media_out,
   input wire logic i_bypass_media,
   input wire logic i_last_sheet,
   // Actuators
   output logic o_pickup_motor,
   output logic o_cassette_solenoid,
   output logic o_bypass_solenoid,
   output logic o_lifter_motor
);

   // ***************************************************
   // Input synchronisers
   // ***************************************************
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   logic [2:0] width_s;
   logic [2:0] end_s;
   logic surface_s;
   logic media_out_s;
   logic byp_media_s;
   logic last_sheet_s;

   // Two flops per pin
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= {i_width_sw, i_end_sw, i_stack_surface_sensor, i_cassette_media_out,
                       i_bypass_media, i_last_sheet};
         sync2_reg <= sync1_reg;
      end
   end

   assign {width_s, end_s, surface_s, media_out_s, byp_media_s, last_sheet_s} = sync2_reg;

   // ***************************************************
   // Millisecond tick divider
   // ***************************************************
   logic [31:0] div_reg;
   logic tick;

   // One-cycle enable every millisecond
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n || tick)
         div_reg <= '0;
      else
         div_reg <= div_reg + 32'h1;
   end

   assign tick = (div_reg == 32'(TICK_CYCLES - 1));

   // ***************************************************
   // Registers
   // ***************************************************
   logic [15:0] sol_dly_reg;
   logic [15:0] lift_tmo_reg;
   logic [15:0] pick_len_reg;
   logic tray_reg;
   logic cont_reg;
   logic wb_hit;
   logic wr_ctrl;
   logic start_req;
   logic raise_req;
   logic ls_clr;

   assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr_ctrl = wb_hit && i_wb_we && i_wb_sel[0] && (i_wb_adr == PPS_ADDR_CTRL);
   assign start_req = wr_ctrl && i_wb_dat[PPS_CTRL_START_BIT];
   assign raise_req = wr_ctrl && i_wb_dat[PPS_CTRL_RAISE_BIT];
   assign ls_clr = wr_ctrl && i_wb_dat[PPS_CTRL_LSCLR_BIT];

   // Configuration writes, low half-word lanes
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         sol_dly_reg <= PPS_SOL_DLY_RST;
         lift_tmo_reg <= PPS_LIFT_TMO_RST;
         pick_len_reg <= PPS_PICK_LEN_RST;
         tray_reg <= 1'b0;
         cont_reg <= 1'b0;
      end
      else if (wb_hit && i_wb_we)
      begin
         case (i_wb_adr)
            PPS_ADDR_CTRL:
            begin
               if (i_wb_sel[0])
               begin
                  tray_reg <= i_wb_dat[PPS_CTRL_TRAY_BIT];
                  cont_reg <= i_wb_dat[PPS_CTRL_CONT_BIT];
               end
            end
            PPS_ADDR_SOL_DLY:
            begin
               if (i_wb_sel[0]) sol_dly_reg[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) sol_dly_reg[15:8] <= i_wb_dat[15:8];
            end
            PPS_ADDR_LIFT_TMO:
            begin
               if (i_wb_sel[0]) lift_tmo_reg[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) lift_tmo_reg[15:8] <= i_wb_dat[15:8];
            end
            PPS_ADDR_PICK_LEN:
            begin
               if (i_wb_sel[0]) pick_len_reg[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) pick_len_reg[15:8] <= i_wb_dat[15:8];
            end
            default:
            begin
            end
         endcase
      end
   end

   // ***************************************************
   // Size decode and presence
   // ***************************************************
   pps_size_t size_next;
   logic absent_reg;
   logic empty_reg;
   logic byp_loaded_reg;
   pps_size_t size_reg;

   // Width switches top,centre,bottom; end switches top,centre,bottom
   always_comb
   begin
      size_next = PPS_SZ_UNKNOWN; // [R17]
      if (end_s[2])
         size_next = PPS_SZ_NONE; // [R7]
      else if (end_s[1:0] == 2'b00)
      begin
         case (width_s) // [R9]
            3'b111: size_next = PPS_SZ_A4;
            3'b110: size_next = PPS_SZ_LETTER;
            3'b100: size_next = PPS_SZ_B5;
            3'b000: size_next = PPS_SZ_EXEC;
            3'b011: size_next = PPS_SZ_A5R;
            3'b001: size_next = PPS_SZ_B5R;
            3'b101: size_next = PPS_SZ_LETTERR;
            default: size_next = PPS_SZ_UNKNOWN;
         endcase
      end
      else if (end_s[1:0] == 2'b01)
      begin
         if (width_s == 3'b101)
            size_next = PPS_SZ_A4R; // [R10]
      end
      else if (end_s[1:0] == 2'b11)
      begin
         case (width_s) // [R10]
            3'b111: size_next = PPS_SZ_A3;
            3'b110: size_next = PPS_SZ_LEDGER;
            3'b100: size_next = PPS_SZ_B4;
            3'b101: size_next = PPS_SZ_LEGAL;
            default: size_next = PPS_SZ_UNKNOWN;
         endcase
      end
   end

   // Registered sensor reports
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         size_reg <= PPS_SZ_NONE;
         absent_reg <= 1'b1;
         empty_reg <= 1'b0;
         byp_loaded_reg <= 1'b0;
      end
      else
      begin
         size_reg <= size_next;
         absent_reg <= end_s[2]; // [R7] [R8]
         empty_reg <= !end_s[2] && media_out_s; // [R11]
         byp_loaded_reg <= byp_media_s; // [R13]
      end
   end

   // ***************************************************
   // Lifter control
   // ***************************************************
   logic lift_reg;
   logic lfault_reg;
   logic boot_reg;
   logic [15:0] lift_ms_reg;
   logic inserted;

   assign inserted = absent_reg && !end_s[2];

   // Raise on power-up, insertion, rack loss; fault on timeout
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         lift_reg <= 1'b0;
         lfault_reg <= 1'b0;
         boot_reg <= 1'b1;
         lift_ms_reg <= '0;
      end
      else
      begin
         boot_reg <= 1'b0;
         if (end_s[2])
            lift_reg <= 1'b0;
         else if (boot_reg || inserted || raise_req)
         begin
            lift_reg <= 1'b1; // [R3]
            lfault_reg <= 1'b0; // [R16]
            lift_ms_reg <= '0;
         end
         else if (lift_reg)
         begin
            if (surface_s)
               lift_reg <= 1'b0; // [R4]
            else if (lift_ms_reg >= lift_tmo_reg)
            begin
               lift_reg <= 1'b0; // [R16]
               lfault_reg <= 1'b1; // [R5]
            end
            else if (tick)
               lift_ms_reg <= lift_ms_reg + 16'h1;
         end
         else if (!surface_s && !lfault_reg)
         begin
            lift_reg <= 1'b1; // [R6]
            lift_ms_reg <= '0;
         end
      end
   end

   // ***************************************************
   // Pickup sequencer
   // ***************************************************
   typedef enum logic [1:0] {PPS_IDLE, PPS_MOTOR, PPS_SOLENOID} pps_state_t;
   pps_state_t state_reg;
   logic [15:0] pick_ms_reg;
   logic byp_sel_reg;
   logic byp_out_reg;

   // Motor start, delayed solenoid, feed time
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         state_reg <= PPS_IDLE;
         pick_ms_reg <= '0;
         byp_sel_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            PPS_IDLE:
            begin
               if (start_req)
               begin
                  state_reg <= PPS_MOTOR; // [R1]
                  byp_sel_reg <= i_wb_dat[PPS_CTRL_TRAY_BIT];
                  pick_ms_reg <= '0;
               end
            end
            PPS_MOTOR:
            begin
               if (byp_sel_reg || pick_ms_reg >= sol_dly_reg)
               begin
                  state_reg <= PPS_SOLENOID; // [R2] [R12]
                  pick_ms_reg <= '0;
               end
               else if (tick)
                  pick_ms_reg <= pick_ms_reg + 16'h1;
            end
            PPS_SOLENOID:
            begin
               if (pick_ms_reg >= pick_len_reg)
                  state_reg <= PPS_IDLE;
               else if (tick)
                  pick_ms_reg <= pick_ms_reg + 16'h1;
            end
            default: state_reg <= PPS_IDLE;
         endcase
      end
   end

   // Sticky bypass out-of-media, set wins over clear
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         byp_out_reg <= 1'b0;
      else if (cont_reg && byp_sel_reg && state_reg != PPS_IDLE && last_sheet_s)
         byp_out_reg <= 1'b1; // [R14] [R15]
      else if (ls_clr)
         byp_out_reg <= 1'b0;
   end

   // Actuator outputs from flops
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         o_pickup_motor <= 1'b0;
         o_cassette_solenoid <= 1'b0;
         o_bypass_solenoid <= 1'b0;
         o_lifter_motor <= 1'b0;
      end
      else
      begin
         o_pickup_motor <= (state_reg != PPS_IDLE); // [R1]
         o_cassette_solenoid <= (state_reg == PPS_SOLENOID) && !byp_sel_reg; // [R2]
         o_bypass_solenoid <= (state_reg == PPS_SOLENOID) && byp_sel_reg; // [R12]
         o_lifter_motor <= lift_reg; // [R4]
      end
   end

   // ***************************************************
   // Wishbone read and ack
   // ***************************************************
   logic [31:0] rd_next;

   // Read multiplexer, unmapped reads zero
   always_comb
   begin
      rd_next = 32'h0;
      case (i_wb_adr)
         PPS_ADDR_CTRL: rd_next = {27'h0, 1'b0, 1'b0, cont_reg, tray_reg, 1'b0};
         PPS_ADDR_STATUS:
         begin
            rd_next[PPS_ST_SIZE_LSB +: 4] = size_reg;
            rd_next[PPS_ST_ABSENT_BIT] = absent_reg;
            rd_next[PPS_ST_EMPTY_BIT] = empty_reg;
            rd_next[PPS_ST_LFAULT_BIT] = lfault_reg;
            rd_next[PPS_ST_BYP_LOADED_BIT] = byp_loaded_reg;
            rd_next[PPS_ST_BYP_OUT_BIT] = byp_out_reg;
            rd_next[PPS_ST_BUSY_BIT] = (state_reg != PPS_IDLE);
            rd_next[PPS_ST_LIFTING_BIT] = lift_reg;
         end
         PPS_ADDR_SOL_DLY: rd_next = {16'h0, sol_dly_reg};
         PPS_ADDR_LIFT_TMO: rd_next = {16'h0, lift_tmo_reg};
         PPS_ADDR_PICK_LEN: rd_next = {16'h0, pick_len_reg};
         default: rd_next = 32'h0;
      endcase
   end

   // One-cycle ack, data registered with it
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0;
      end
      else
      begin
         o_wb_ack <= wb_hit;
         o_wb_dat <= wb_hit ? rd_next : 32'h0;
      end
   end

endmodule // pps_paper_pickup_sequencer

// ==== pps_paper_pickup_sequencer_props.sv ====
// Checker of bus and actuator timing for the pickup sequencer
`timescale 1ns/1ps
module pps_pickup_props
   import pps_pkg::*;
#(
   parameter int TICK_CYCLES = PPS_TICK_CYCLES
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Bus
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [5:2] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   // Sensors and actuators
   input wire logic [2:0] i_width_sw,
   input wire logic [2:0] i_end_sw,
   input wire logic i_stack_surface_sensor,
   input wire logic i_cassette_media_out,
   input wire logic i_bypass_media,
   input wire logic i_last_sheet,
   input wire logic o_pickup_motor,
   input wire logic o_cassette_solenoid,
   input wire logic o_bypass_solenoid,
   input wire logic o_lifter_motor
);
   // Shared clock and reset for every check
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("bus request not answered");
   a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_data_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("read data not zero outside ack");
   a_motor_start: assert property ($rose(o_pickup_motor) |-> $past(o_wb_ack))
      else $error("pickup motor started without command");
   a_cas_sol_motor: assert property (o_cassette_solenoid |-> o_pickup_motor)
      else $error("cassette solenoid without motor");
   a_cas_fall_both: assert property ($fell(o_cassette_solenoid) |-> $fell(o_pickup_motor))
      else $error("solenoid and motor did not stop together");
   a_byp_after_motor: assert property ($rose(o_bypass_solenoid) |-> $past(o_pickup_motor))
      else $error("bypass solenoid before motor");
   a_sols_exclusive: assert property (!(o_cassette_solenoid && o_bypass_solenoid))
      else $error("both solenoids driven");
   a_lift_stop: assert property (i_stack_surface_sensor [*8] |-> !o_lifter_motor)
      else $error("lifter runs with rack detected");
   a_lift_absent: assert property (i_end_sw[2] [*8] |-> !o_lifter_motor)
      else $error("lifter runs with cassette missing");
endmodule // pps_pickup_props

bind pps_paper_pickup_sequencer pps_pickup_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
   .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_width_sw(i_width_sw), .i_end_sw(i_end_sw),
   .i_stack_surface_sensor(i_stack_surface_sensor), .i_cassette_media_out(i_cassette_media_out),
   .i_bypass_media(i_bypass_media), .i_last_sheet(i_last_sheet), .o_pickup_motor(o_pickup_motor),
   .o_cassette_solenoid(o_cassette_solenoid), .o_bypass_solenoid(o_bypass_solenoid),
   .o_lifter_motor(o_lifter_motor));

// ==== pps_formatter_model.sv ====
// Formatter side bus master issuing commands over Wishbone
`timescale 1ns/1ps
module pps_formatter_model
(
   // Clock
   input wire logic i_clk,
   // Answer
   input wire logic i_wb_ack,
   input wire logic [31:0] i_wb_dat,
   // Request
   output logic o_wb_cyc,
   output logic o_wb_stb,
   output logic o_wb_we,
   output logic [3:0] o_wb_adr,
   output logic [3:0] o_wb_sel,
   output logic [31:0] o_wb_dat
);
   // Idle bus at time zero
   initial
   begin
      o_wb_cyc = 1'b0;
      o_wb_stb = 1'b0;
      o_wb_we = 1'b0;
      o_wb_adr = 4'h0;
      o_wb_sel = 4'h0;
      o_wb_dat = 32'h0;
   end
   // One classic cycle, held until ack is sampled
   task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rq);
      @(posedge i_clk);
      o_wb_cyc <= 1'b1;
      o_wb_stb <= 1'b1;
      o_wb_we <= we;
      o_wb_adr <= a;
      o_wb_sel <= 4'h3;
      o_wb_dat <= d;
      do
         @(posedge i_clk);
      while (i_wb_ack !== 1'b1);
      rq = i_wb_dat;
      o_wb_cyc <= 1'b0;
      o_wb_stb <= 1'b0;
      o_wb_we <= 1'b0;
      o_wb_adr <= ~a;
      o_wb_dat <= ~d;
   endtask
endmodule // pps_formatter_model

// ==== pps_paper_pickup_sequencer_test.sv ====
// Self-checking bench of the paper pickup sequencer
`timescale 1ns/1ps
module pps_paper_pickup_sequencer_test
   import pps_pkg::*;
();
   // Bench signals
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [2:0] width_sw = 3'h0;
   logic [2:0] end_sw = 3'h0;
   logic stack = 1'b0;
   logic media_out = 1'b0;
   logic byp_media = 1'b0;
   logic last_sheet = 1'b0;
   wire logic cyc, stb, we, ack, pmot, csol, bsol, lmot;
   wire logic [3:0] adr, sel;
   wire logic [31:0] wdat, rdat;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;
   logic [31:0] q;
   // {end switches, width switches, size code}
   logic [9:0] sz_tbl [15] = '{10'h071, 10'h062, 10'h043, 10'h004, 10'h035, 10'h016, 10'h057,
      10'h0d8, 10'h1f9, 10'h1ea, 10'h1cb, 10'h1dc, 10'h18f, 10'h0ff, 10'h270};

   // ***************************************************
   // Instances and clock
   // ***************************************************
   pps_paper_pickup_sequencer #(.TICK_CYCLES(4)) dut_u (.i_clk(clk), .i_reset_n(reset_n),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_width_sw(width_sw),
      .i_end_sw(end_sw), .i_stack_surface_sensor(stack), .i_cassette_media_out(media_out),
      .i_bypass_media(byp_media), .i_last_sheet(last_sheet), .o_pickup_motor(pmot),
      .o_cassette_solenoid(csol), .o_bypass_solenoid(bsol), .o_lifter_motor(lmot));
   pps_formatter_model fm_u (.i_clk(clk), .i_wb_ack(ack), .i_wb_dat(rdat), .o_wb_cyc(cyc),
      .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat));
   initial
   begin
      forever #10 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         report_and_stop();
      end
   end

   // ***************************************************
   // Helper tasks
   // ***************************************************
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] unused;
      fm_u.xfer(1'b1, a, d, unused);
   endtask
   task automatic rd(input logic [3:0] a);
      fm_u.xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      if (failures == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_boot;
      wt(8);
      chk(lmot, 1'b1);
      stack <= 1'b1;
      rd(PPS_ADDR_SOL_DLY);
      chk(q, {16'h0, PPS_SOL_DLY_RST});
      rd(PPS_ADDR_LIFT_TMO);
      chk(q, {16'h0, PPS_LIFT_TMO_RST});
      rd(PPS_ADDR_PICK_LEN);
      chk(q, {16'h0, PPS_PICK_LEN_RST});
      rd(4'h7);
      chk(q, 32'h0);
   endtask
   task automatic t_size;
      for (int i = 0; i < 15; i++)
      begin
         end_sw <= sz_tbl[i][9:7];
         width_sw <= sz_tbl[i][6:4];
         wt(6);
         rd(PPS_ADDR_STATUS);
         chk(q[3:0], sz_tbl[i][3:0]);
         chk(q[PPS_ST_ABSENT_BIT], sz_tbl[i][9]);
         chk(q[PPS_ST_EMPTY_BIT], 1'b0);
      end
      stack <= 1'b0;
      wt(10);
      chk(lmot, 1'b0);
      end_sw <= 3'h0;
      wt(6);
      chk(lmot, 1'b1);
      stack <= 1'b1;
      media_out <= 1'b1;
      wt(8);
      chk(lmot, 1'b0);
      rd(PPS_ADDR_STATUS);
      chk(q[PPS_ST_EMPTY_BIT], 1'b1);
      media_out <= 1'b0;
   endtask
   task automatic t_lift;
      stack <= 1'b0;
      wt(6);
      chk(lmot, 1'b1);
      stack <= 1'b1;
      wt(8);
      wr(PPS_ADDR_LIFT_TMO, 32'h4);
      stack <= 1'b0;
      wt(30);
      rd(PPS_ADDR_STATUS);
      chk(q[PPS_ST_LFAULT_BIT], 1'b1);
      wt(6);
      chk(lmot, 1'b0);
      wr(PPS_ADDR_CTRL, 32'h8);
      rd(PPS_ADDR_STATUS);
      chk(q[PPS_ST_LFAULT_BIT], 1'b0);
      chk(lmot, 1'b1);
      stack <= 1'b1;
      wt(8);
   endtask
   task automatic t_cassette;
      wr(PPS_ADDR_SOL_DLY, 32'h3);
      wr(PPS_ADDR_PICK_LEN, 32'h2);
      wr(PPS_ADDR_CTRL, 32'h1);
      for (n = 0; n < 60 && csol !== 1'b1; n++)
         @(posedge clk);
      chk(n >= 9 && n <= 20, 1'b1);
      rd(PPS_ADDR_STATUS);
      chk(q[PPS_ST_BUSY_BIT], 1'b1);
      for (n = 0; n < 60 && pmot !== 1'b0; n++)
         @(posedge clk);
      chk(csol, 1'b0);
   endtask
   task automatic t_bypass;
      last_sheet <= 1'b1;
      wt(6);
      rd(PPS_ADDR_STATUS);
      chk(q[PPS_ST_BYP_LOADED_BIT], 1'b0);
      chk(q[PPS_ST_BYP_OUT_BIT], 1'b0);
      byp_media <= 1'b1;
      wt(6);
      rd(PPS_ADDR_STATUS);
      chk(q[PPS_ST_BYP_LOADED_BIT], 1'b1);
      wr(PPS_ADDR_CTRL, 32'h7);
      for (n = 0; n < 20 && pmot !== 1'b1; n++)
         @(posedge clk);
      @(posedge clk);
      chk(bsol, 1'b1);
      wt(6);
      rd(PPS_ADDR_STATUS);
      chk(q[PPS_ST_BYP_OUT_BIT], 1'b1);
      last_sheet <= 1'b0;
      for (n = 0; n < 60 && pmot !== 1'b0; n++)
         @(posedge clk);
      wr(PPS_ADDR_CTRL, 32'h10);
      rd(PPS_ADDR_STATUS);
      chk(q[PPS_ST_BYP_OUT_BIT], 1'b0);
   endtask

   // Main sequence
   initial
   begin
      wt(4);
      reset_n <= 1'b1;
      t_boot();
      t_size();
      t_lift();
      t_cassette();
      t_bypass();
      report_and_stop();
   end
endmodule // pps_paper_pickup_sequencer_test
